// File: hw/quadrature_position_control.sv
`timescale 1ns/1ps
// Function
// - Mode 111 decodes four edges per cycle and wraps the counter at the max-count limit.
// - Mode 110 decodes four edges per cycle and lets the marker pulse clear the counter.
// - Mode 101 decodes two edges per cycle and wraps the counter at the max-count limit.
// - Mode 100 decodes two edges per cycle and lets the marker pulse clear the counter.
// - Codes 011 and 010 leave both decoding and the timer idle with no counting.
// - Mode 001 runs the position counter as a plain 16-bit timer.
// - Mode 000 turns both decoding and the timer off.
// - The direction bit reads 1 for up, is read-only in 1xx and writable in 001.
// - The swap bit exchanges phase A and phase B before decoding.
// - The gate enable lets the timer count only while the gate input is high.
// - A marker pulse clears the counter only with the reset enable set, in 100 and 110.
// - The timer clock source bit picks phase A rising edges or the system clock.
module quadrature_position_control
    import qpos_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic phase_a_pin,
    input wire logic phase_b_pin,
    input wire logic marker_pin,
    input wire logic idle_mode_pin,
    output logic direction_out,
    output logic direction_out_en,
    output logic irq
);

    ctrl_s ctrl_reg;
    logic err_reg;
    logic dir_reg;
    logic [15:0] pos_reg;
    logic [15:0] pos_next;
    logic [15:0] max_reg;
    logic [IRQ_W-1:0] stat_reg;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] events;
    logic ack_reg;
    logic [31:0] rdata;
    logic [3:0] pin_raw;
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] prev_reg;
    logic req;
    logic wr;
    logic rd;
    logic [15:0] wmerge_ctrl;
    logic [15:0] wmerge_pos;
    logic [15:0] wmerge_max;
    logic qa;
    logic qb;
    logic pa;
    logic pb;
    logic a_chg;
    logic b_chg;
    logic marker_rise;
    logic quad;
    logic x4;
    logic mark_mode;
    logic timer_mode;
    logic halt;
    logic quad_step;
    logic step_up;
    logic tmr_tick;
    logic tmr_up;
    logic step;
    logic up;
    logic wrap;
    logic marker_clear;
    logic count_err;
    mode_e mode;

    // Merges write data into a 16-bit register under the byte enables.
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] sel
    );
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = data[7:0];
        end
        if (sel[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // Bus decode: one request per cycle pair, answered by a registered ack.
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    assign wb_ack_o = ack_reg;
    assign wmerge_ctrl = merge16(ctrl_reg, wb_dat_i, wb_sel_i);
    assign wmerge_pos = merge16(pos_reg, wb_dat_i, wb_sel_i);
    assign wmerge_max = merge16(max_reg, wb_dat_i, wb_sel_i);

    // Ack follows each request by one cycle and drops after one.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Two-stage synchronisers for the encoder and idle pins.
    assign pin_raw = {idle_mode_pin, marker_pin, phase_b_pin, phase_a_pin};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    prev_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= pin_raw[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    prev_reg[gi] <= s2_reg[gi];
                end
            end
        end
    endgenerate

    assign qa = ctrl_reg.phase_swap_select ? s2_reg[PIN_B] : s2_reg[PIN_A];
    assign qb = ctrl_reg.phase_swap_select ? s2_reg[PIN_A] : s2_reg[PIN_B];
    assign pa = ctrl_reg.phase_swap_select ? prev_reg[PIN_B] : prev_reg[PIN_A];
    assign pb = ctrl_reg.phase_swap_select ? prev_reg[PIN_A] : prev_reg[PIN_B];
    assign a_chg = qa ^ pa;
    assign b_chg = qb ^ pb;
    assign marker_rise = s2_reg[PIN_M] & ~prev_reg[PIN_M];

    // Mode decode; codes 000, 010 and 011 enable nothing.
    assign mode = ctrl_reg.encoder_mode_field;
    assign quad = mode[2];
    assign x4 = mode[1];
    assign mark_mode = quad & ~mode[0];
    assign timer_mode = (mode == MODE_TIMER);

    assign halt = ctrl_reg.idle_stop_select & s2_reg[PIN_N];

    // Quadrature step: both phases moving at once is a glitch and is dropped.
    // four-edge decode, or phase A edges only in two-edge modes
    assign quad_step = quad & (a_chg ^ b_chg) & (x4 | a_chg);
    assign step_up = qa ^ pb;

    always_comb begin
        tmr_tick = 1'b0;
        if (timer_mode) begin
            if (ctrl_reg.timer_clock_source) begin
                tmr_tick = qa & ~pa;
            end else if (ctrl_reg.gated_accumulate_enable) begin
                tmr_tick = qa;
            end else begin
                tmr_tick = 1'b1;
            end
        end
    end
    assign tmr_up = ctrl_reg.direction_source_select ? qb : dir_reg;

    // Common step, direction and wrap at the limits.
    assign step = ~halt & (quad_step | tmr_tick);
    assign up = quad ? step_up : tmr_up;
    assign wrap = step & (up ? (pos_reg == max_reg) : (pos_reg == POS_RESET));

    assign marker_clear = mark_mode & ctrl_reg.marker_reset_enable & marker_rise & ~halt;

    assign count_err = mark_mode & wrap & ~marker_clear;

    // Next counter value: software write, then marker clear, then a step.
    always_comb begin
        pos_next = pos_reg;
        if (wr && wb_adr_i == OFS_POS) begin
            pos_next = wmerge_pos;
        end else if (marker_clear) begin
            pos_next = POS_RESET;
        end else if (wrap) begin
            pos_next = up ? POS_RESET : max_reg;
        end else if (step) begin
            pos_next = up ? pos_reg + 16'h0001 : pos_reg - 16'h0001;
        end
    end

    // Position counter and limit registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_reg <= POS_RESET;
            max_reg <= MAX_RESET;
        end else begin
            pos_reg <= pos_next;
            if (wr && wb_adr_i == OFS_MAX) begin
                max_reg <= wmerge_max;
            end
        end
    end

    // Control fields; the status bits are kept in their own registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr && wb_adr_i == OFS_CTRL) begin
            ctrl_reg <= wmerge_ctrl;
        end
    end

    // Error flag: writing zero clears it, a new error in that cycle wins.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_reg <= 1'b0;
        end else if (count_err) begin
            err_reg <= 1'b1;
        end else if (wr && wb_adr_i == OFS_CTRL && wb_sel_i[1]) begin
            err_reg <= err_reg & wb_dat_i[15];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_reg <= 1'b0;
        end else if (quad) begin
            if (quad_step) begin
                dir_reg <= step_up;
            end
        end else if (timer_mode && wr && wb_adr_i == OFS_CTRL && wb_sel_i[1]) begin
            dir_reg <= wb_dat_i[11];
        end
    end

    // Direction pin driven from the direction bit.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            direction_out <= 1'b0;
            direction_out_en <= 1'b0;
        end else begin
            direction_out <= dir_reg;
            direction_out_en <= ctrl_reg.direction_output_enable;
        end
    end

    // Interrupt events: count error and any counter reset or wrap.
    assign events[IRQ_ERR] = count_err;
    assign events[IRQ_WRAP] = wrap | marker_clear;

    // Sticky status cleared by a read; an event in the read cycle survives.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_reg <= IRQ_RESET;
            mask_reg <= IRQ_RESET;
        end else begin
            if (rd && wb_adr_i == OFS_STAT) begin
                stat_reg <= events;
            end else begin
                stat_reg <= stat_reg | events;
            end
            if (wr && wb_adr_i == OFS_MASK && wb_sel_i[0]) begin
                mask_reg <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // Level interrupt while any unmasked status bit is set.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_reg & mask_reg);
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rdata = 32'h00000000;
        case (wb_adr_i)
            OFS_CTRL: begin
                rdata[15:0] = ctrl_reg;
                rdata[15] = err_reg;
                rdata[14] = 1'b0;
                rdata[12] = s2_reg[PIN_M];
                rdata[11] = dir_reg;
            end
            OFS_POS: begin
                rdata[15:0] = pos_reg;
            end
            OFS_MAX: begin
                rdata[15:0] = max_reg;
            end
            OFS_STAT: begin
                rdata[IRQ_W-1:0] = stat_reg;
            end
            OFS_MASK: begin
                rdata[IRQ_W-1:0] = mask_reg;
            end
            default: begin
                rdata = 32'h00000000;
            end
        endcase
    end

    // Read data is captured with the request and shown with ack.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (rd) begin
            wb_dat_o <= rdata;
        end
    end

endmodule

// File: inc/qpos_pkg.sv
package qpos_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POS = 8'h04;
    localparam logic [7:0] OFS_MAX = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;

    // Reset values.
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] POS_RESET = 16'h0000;
    localparam logic [15:0] MAX_RESET = 16'hFFFF;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // Interrupt status bit positions.
    localparam int IRQ_ERR = 0;
    localparam int IRQ_WRAP = 1;
    localparam int IRQ_W = 2;

    // Synchronised pin positions.
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_M = 2;
    localparam int PIN_N = 3;

    // Operating modes of the encoder mode field.
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_TIMER = 3'h1,
        MODE_UNUSED2 = 3'h2,
        MODE_UNUSED3 = 3'h3,
        MODE_X2_MARK = 3'h4,
        MODE_X2_MATCH = 3'h5,
        MODE_X4_MARK = 3'h6,
        MODE_X4_MATCH = 3'h7
    } mode_e;

    // Layout of the encoder control register.
    typedef struct packed {
        logic count_error_flag;
        logic unused_14;
        logic idle_stop_select;
        logic marker_pin_state;
        logic count_direction_bit;
        mode_e encoder_mode_field;
        logic phase_swap_select;
        logic direction_output_enable;
        logic gated_accumulate_enable;
        logic [1:0] prescale_select;
        logic marker_reset_enable;
        logic timer_clock_source;
        logic direction_source_select;
    } ctrl_s;

endpackage

// File: tb/encoder_model.sv
`timescale 1ns/1ps
// Incremental encoder that walks a Gray phase and drives a marker.
module encoder_model (
    input wire logic clk,
    output logic phase_a,
    output logic phase_b,
    output logic marker
);
    logic [1:0] ph = 2'h0;
    // One phase step, each level then held four clocks.
    task automatic step(input logic up);
        ph <= up ? ph + 2'h1 : ph - 2'h1;
        repeat (4) @(posedge clk);
    endtask
    // Phase A leads phase B on an upward step.
    assign phase_a = (ph == 2'h1) || (ph == 2'h2);
    assign phase_b = ph[1];
    initial marker = 1'b0;
endmodule

// File: tb/qpos_checker.sv
`timescale 1ns/1ps
// Watches bus answers and output levels at the top-level ports.
module qpos_checker
    import qpos_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic direction_out_en,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rd_take;
    // A read is taken when the strobe meets an idle acknowledge.
    assign rd_take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr(logic [7:0] a);
        s_take ##0 wb_we_i && wb_adr_i == a && wb_sel_i[0];
    endsequence
    property p_out_en;
        logic v;
        (s_wr(OFS_CTRL), v = wb_dat_i[6]) |-> ##2 direction_out_en == v;
    endproperty
    a_ack_answer: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_data_hold: assert property (!rd_take |=> $stable(wb_dat_o))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd_take && wb_adr_i > OFS_MASK |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_out_en_copy: assert property (p_out_en)
        else $error("output enable does not follow control");
    a_irq_mask_off: assert property (s_wr(OFS_MASK) ##0 wb_dat_i[1:0] == 2'h0 |=> ##1 !irq)
        else $error("irq high with mask cleared");
    a_reset_quiet: assert property ($fell(rst) |-> !wb_ack_o && !irq && !direction_out_en)
        else $error("outputs active after reset");
endmodule

// File: tb/quadrature_position_control_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module quadrature_position_control_tb;
    import qpos_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, irq, dout, doen, pa, pb, pm;
    logic [15:0] q_exp[$];
    logic [15:0] q_msk[$];
    logic [15:0] v;
    int err_total = 0;
    int total_checks = 0;
    int seed = 47;
    quadrature_position_control dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .phase_a_pin(pa), .phase_b_pin(pb), .marker_pin(pm),
        .idle_mode_pin(idle), .direction_out(dout), .direction_out_en(doen), .irq(irq));
    encoder_model enc (.clk(clk), .phase_a(pa), .phase_b(pb), .marker(pm));
    initial forever #4 clk = ~clk;
    // Compares each read answer with the oldest noted expectation.
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && q_exp.size() > 0) begin
            `CHK(rdat[15:0] & q_msk[0], q_exp[0] & q_msk[0])
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
        end
    end
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One classic cycle, held until the acknowledge is sampled.
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h3;
        wdat <= {16'h0000, d};
        for (n = 0; n < 50 && ack !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (n == 50) begin
            err_total++;
            complete_run();
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        q_exp.push_back(e);
        q_msk.push_back(m);
        bus(1'b0, a, 16'h0000);
    endtask
    // Sets mode, loads the counter, then walks the encoder.
    task automatic go(input logic [15:0] c, input logic [15:0] p, input int n, input logic up);
        wr(OFS_CTRL, c);
        wr(OFS_POS, p);
        repeat (n) enc.step(up);
    endtask
    // Marker pulse, with its level read back while high.
    task automatic pulse();
        enc.marker <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFS_CTRL, 16'h1000, 16'h1000);
        enc.marker <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Main sequence of scenarios.
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_CTRL, CTRL_RESET, 16'hFFFF);
        rd(OFS_POS, POS_RESET, 16'hFFFF);
        rd(OFS_MAX, MAX_RESET, 16'hFFFF);
        rd(OFS_STAT, 16'h0000, 16'hFFFF);
        rd(OFS_MASK, 16'h0000, 16'hFFFF);
        rd(8'h14, 16'h0000, 16'hFFFF);
        $display("end reset values");
        for (int i = 0; i < 8; i++) begin
            if (i != 1) begin
                go({5'h00, i[2:0], 8'h00}, 16'h0000, 4, 1'b1);
                rd(OFS_POS, (i >= 6) ? 16'h4 : (i >= 4) ? 16'h2 : 16'h0, 16'hFFFF);
                rd(OFS_CTRL, 16'h0800, {4'h0, i[2], 11'h0});
            end
        end
        $display("end mode table");
        v = 16'h0100 + 16'($random(seed) & 32'hFF);
        go(16'h0780, v, 2, 1'b1);
        rd(OFS_POS, v - 16'h0002, 16'hFFFF);
        $display("end phase swap");
        go(16'h0604, 16'h0030, 0, 1'b1);
        pulse();
        rd(OFS_POS, 16'h0000, 16'hFFFF);
        go(16'h0404, 16'h0030, 0, 1'b1);
        pulse();
        rd(OFS_POS, 16'h0000, 16'hFFFF);
        go(16'h0600, 16'h0030, 0, 1'b1);
        pulse();
        rd(OFS_POS, 16'h0030, 16'hFFFF);
        $display("end marker clear");
        wr(OFS_MAX, 16'h0003);
        go(16'h0600, 16'h0003, 1, 1'b1);
        rd(OFS_CTRL, 16'h8000, 16'h8000);
        rd(OFS_STAT, 16'h0001, 16'h0001);
        $display("end count error");
        wr(OFS_MAX, 16'h0005);
        wr(OFS_MASK, 16'h0003);
        go(16'h0700, 16'h0000, 2, 1'b0);
        rd(OFS_POS, 16'h0004, 16'hFFFF);
        rd(OFS_CTRL, 16'h0000, 16'h0800);
        // A direction write in quadrature mode is ignored; the pin enable is set.
        wr(OFS_CTRL, 16'h0F40);
        rd(OFS_CTRL, 16'h0000, 16'h0800);
        `CHK(doen, 1'b1)
        `CHK(dout, 1'b0)
        `CHK(irq, 1'b1)
        rd(OFS_STAT, 16'h0002, 16'h0003);
        `CHK(irq, 1'b0)
        wr(OFS_MASK, 16'h0000);
        $display("end wrap and irq");
        idle <= 1'b1;
        go(16'h2700, 16'h0000, 4, 1'b1);
        rd(OFS_POS, 16'h0000, 16'hFFFF);
        idle <= 1'b0;
        $display("end idle stop");
        // The second write lands in timer mode, where the direction bit is writable.
        wr(OFS_CTRL, 16'h0100);
        wr(OFS_CTRL, 16'h0100);
        rd(OFS_CTRL, 16'h0000, 16'h0800);
        go(16'h0902, 16'h0000, 6, 1'b1);
        rd(OFS_CTRL, 16'h0800, 16'h0800);
        `CHK(dout, 1'b1)
        rd(OFS_POS, 16'h0001, 16'hFFFF);
        // Six steps leave phase A low, so the gate stays shut.
        go(16'h0920, 16'h0000, 0, 1'b1);
        repeat (20) @(posedge clk);
        rd(OFS_POS, 16'h0000, 16'hFFFF);
        // Internal clock: the counter moves once per clock after its load.
        go(16'h0900, 16'h0000, 0, 1'b1);
        rd(OFS_POS, 16'h0002, 16'hFFFF);
        $display("end timer");
        complete_run();
    end
endmodule
bind quadrature_position_control qpos_checker chk (.clk(clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .direction_out_en(direction_out_en), .irq(irq));
